// ===== hdl/fl_pkg.sv
// package: opcodes, timing counts and state records of the flash sequencer
// assumes a 50 MHz core clock and a serial clock driven by the host
package fl_pkg;
    localparam int CLK_NS     = 20;
    localparam int PP_TIME_US = 10;                     // page program time limit
    localparam int PP_CYC     = PP_TIME_US * 1000 / CLK_NS;
    localparam int DUMMY_CYC  = 8;                      // fast read dummy clocks
    localparam int MEM_AW     = 12;                     // address bits of the array model, 4096 bytes
    localparam int PAGE_B     = 256;

    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DOUT = 8'h3B;
    localparam logic [7:0] OP_DIO  = 8'hBB;
    localparam logic [7:0] OP_QOUT = 8'h6B;
    localparam logic [7:0] OP_QIO  = 8'hEB;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PP   = 8'h02;
    localparam logic [7:0] OP_DPP  = 8'hA2;
    localparam logic [7:0] OP_XDPP = 8'hD2;
    localparam logic [7:0] OP_QPP  = 8'h32;
    localparam logic [7:0] OP_XQPP = 8'h12;

    localparam logic [1:0] PR_EXT  = 2'h0;
    localparam logic [1:0] PR_DUAL = 2'h1;
    localparam logic [1:0] PR_QUAD = 2'h2;
    localparam logic [1:0] PH_CMD  = 2'h0;
    localparam logic [1:0] PH_ADDR = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    localparam logic [3:0] OE_ONE  = 4'h2;
    localparam logic [3:0] OE_TWO  = 4'h3;
    localparam logic [3:0] OE_FOUR = 4'hF;

    typedef enum logic [5:0] {
        L_CMD = 6'h01, L_ADDR = 6'h02, L_DUMMY = 6'h04,
        L_RDATA = 6'h08, L_PDATA = 6'h10, L_IGNORE = 6'h20
    } link_st_e;
    typedef enum logic [1:0] {C_IDLE = 2'h1, C_PROG = 2'h2} core_st_e;

    typedef struct packed {
        link_st_e     st;
        logic [7:0]   op;
        logic [23:0]  addr;
        logic [7:0]   dsh;
        logic [4:0]   cnt;
        logic [7:0]   col;
        logic [255:0] pmask;
        logic         op_done;
        logic         over;
        logic         got_byte;
        logic         ftog;
        logic [2:0]   wip_s;
        logic         wip_q;
    } link_s;
    typedef struct packed {
        logic [7:0] osh;
        logic [3:0] ocnt;
        logic [3:0] dq_o;
        logic [3:0] dq_oe;
    } out_s;
    typedef struct packed {
        core_st_e     st;
        logic         wel;
        logic         wip;
        logic         fail;
        logic         prot;
        logic [9:0]   tmr;
        logic [7:0]   col;
        logic [3:0]   base;
        logic         seen;
        logic [2:0]   cs_s;
        logic         cs_q;
        logic [2:0]   stl_s;
        logic         stl_q;
        logic [2:0]   clr_s;
        logic         clr_q;
        logic [255:0] lock1;
        logic [255:0] lock2;
        logic [255:0] lock3;
        logic [255:0] lockq;
    } core_s;

    localparam link_s LINK_RST = '{st: L_IGNORE, default: '0};
    localparam out_s  OUT_RST  = '0;
    // chip select sync starts at its idle high level, so no false rise follows reset
    localparam core_s CORE_RST = '{st: C_IDLE, cs_s: 3'h7, cs_q: 1'b1, default: '0};
endpackage

// ===== hdl/fl_seq.sv
// serial flash read / page program sequencer with a small array model
// assumes mode 0 host clocking; sclk idle while cs_n is high
`timescale 1ns/100ps
module fl_seq (
    input  logic         ref_clk,
    input  logic         rst_n,
    input  logic         sclk,
    input  logic         cs_n,
    input  logic [3:0]   dq_i,
    output logic [3:0]   dq_o,
    output logic [3:0]   dq_oe,
    input  logic [1:0]   proto,
    input  logic [255:0] sector_lock,
    input  logic         array_stall,
    input  logic         flag_clr,
    output logic         wip,
    output logic         wel,
    output logic         prog_fail,
    output logic         prot_err
);
    localparam int PP_LIM = fl_pkg::PP_CYC + 1;

    fl_pkg::link_s              lk;
    fl_pkg::link_s              next_lk;
    fl_pkg::out_s               ob;
    fl_pkg::out_s               next_ob;
    fl_pkg::core_s              c;
    fl_pkg::core_s              next_c;
    logic                       in_frame;
    logic                       fr_rst;
    logic [7:0]                 pbuf [fl_pkg::PAGE_B];
    logic [7:0]                 mem [2**fl_pkg::MEM_AW];
    logic                       pb_we;
    logic [7:0]                 pb_idx;
    logic [7:0]                 pb_dat;
    logic                       mem_we;
    logic [fl_pkg::MEM_AW-1:0]  mem_idx;
    logic [7:0]                 mem_dat;
    logic [2:0]                 lw;
    logic [4:0]                 lcnt;
    logic                       byte_end;

    // lanes used by a phase of a command under a protocol
    function automatic logic [2:0] lanes(input logic [7:0] op, input logic [1:0] pr,
                                         input logic [1:0] ph);
        lanes = 3'h1;
        if (pr == fl_pkg::PR_DUAL) begin
            lanes = 3'h2;
        end else if (pr == fl_pkg::PR_QUAD) begin
            lanes = 3'h4;
        end else if (ph != fl_pkg::PH_CMD) begin
            case (op)
                fl_pkg::OP_DIO, fl_pkg::OP_XDPP: lanes = 3'h2;
                fl_pkg::OP_QIO, fl_pkg::OP_XQPP: lanes = 3'h4;
                fl_pkg::OP_DOUT, fl_pkg::OP_DPP: begin
                    if (ph == fl_pkg::PH_DATA) lanes = 3'h2;
                end
                fl_pkg::OP_QOUT, fl_pkg::OP_QPP: begin
                    if (ph == fl_pkg::PH_DATA) lanes = 3'h4;
                end
                default: lanes = 3'h1;
            endcase
        end
    endfunction

    // read opcodes accepted under a protocol
    function automatic logic is_read(input logic [7:0] op, input logic [1:0] pr);
        case (op)
            fl_pkg::OP_FAST:                 is_read = 1'b1;
            fl_pkg::OP_READ:                 is_read = (pr == fl_pkg::PR_EXT);
            fl_pkg::OP_DOUT, fl_pkg::OP_DIO: is_read = (pr != fl_pkg::PR_QUAD);
            fl_pkg::OP_QOUT, fl_pkg::OP_QIO: is_read = (pr != fl_pkg::PR_DUAL);
            default:                         is_read = 1'b0;
        endcase
    endfunction

    // program opcodes accepted under a protocol
    function automatic logic is_prog(input logic [7:0] op, input logic [1:0] pr);
        case (op)
            fl_pkg::OP_PP:                    is_prog = 1'b1;
            fl_pkg::OP_DPP, fl_pkg::OP_XDPP:  is_prog = (pr != fl_pkg::PR_QUAD);
            fl_pkg::OP_QPP, fl_pkg::OP_XQPP:  is_prog = (pr != fl_pkg::PR_DUAL);
            default:                          is_prog = 1'b0;
        endcase
    endfunction

    // shift one clock worth of lane bits into a word
    function automatic logic [23:0] shin(input logic [23:0] v, input logic [3:0] d,
                                         input logic [2:0] w);
        case (w)
            3'h4:    shin = {v[19:0], d};
            3'h2:    shin = {v[21:0], d[1:0]};
            default: shin = {v[22:0], d[0]};
        endcase
    endfunction

    // frame marker: cleared while cs_n is high, set by the first edge
    assign fr_rst = !rst_n || cs_n;
    always_ff @(posedge sclk or posedge fr_rst) begin
        if (fr_rst) in_frame <= 1'b0;
        else        in_frame <= 1'b1;
    end

    // link side decoder, runs on rising serial clock edges
    always_comb begin
        fl_pkg::link_s b;
        logic [23:0]   sv;
        b = lk;
        sv = '0;
        if (!in_frame) begin
            b.st = fl_pkg::L_CMD;
            b.cnt = '0;
            b.op = '0;
            b.op_done = 1'b0;
            b.over = 1'b0;
            b.got_byte = 1'b0;
            b.ftog = !lk.ftog;
        end
        next_lk = b;
        next_lk.wip_s = {lk.wip_s[1:0], c.wip};
        if (lk.wip_s[1] == lk.wip_s[2]) next_lk.wip_q = lk.wip_s[2];
        lw = lanes(b.op, proto, (b.st == fl_pkg::L_CMD) ? fl_pkg::PH_CMD :
                   (b.st == fl_pkg::L_ADDR) ? fl_pkg::PH_ADDR : fl_pkg::PH_DATA);
        lcnt = b.cnt + {2'h0, lw};
        byte_end = (lcnt == 5'h08);
        pb_we = 1'b0;
        pb_idx = b.col;
        pb_dat = '0;
        case (b.st)
            fl_pkg::L_CMD: begin
                sv = shin({16'h0000, b.dsh}, dq_i, lw);
                next_lk.dsh = sv[7:0];
                next_lk.cnt = lcnt;
                if (byte_end) begin
                    next_lk.op = sv[7:0];
                    next_lk.op_done = 1'b1;
                    next_lk.cnt = '0;
                    if (is_read(sv[7:0], proto) || is_prog(sv[7:0], proto))
                        next_lk.st = fl_pkg::L_ADDR;
                    else
                        next_lk.st = fl_pkg::L_IGNORE;
                end
            end
            fl_pkg::L_ADDR: begin
                sv = shin(b.addr, dq_i, lw);
                next_lk.addr = sv;
                next_lk.cnt = lcnt;
                if (lcnt == 5'h18) begin
                    next_lk.cnt = '0;
                    next_lk.col = sv[7:0];
                    next_lk.pmask = '0;
                    if (lk.wip_q)
                        next_lk.st = fl_pkg::L_IGNORE;
                    else if (is_prog(b.op, proto))
                        next_lk.st = fl_pkg::L_PDATA;
                    else if (b.op == fl_pkg::OP_READ)
                        next_lk.st = fl_pkg::L_RDATA;
                    else
                        next_lk.st = fl_pkg::L_DUMMY;
                end
            end
            fl_pkg::L_DUMMY: begin
                next_lk.cnt = b.cnt + 5'h01;
                if (b.cnt == 5'(fl_pkg::DUMMY_CYC - 1)) begin
                    next_lk.cnt = '0;
                    next_lk.st = fl_pkg::L_RDATA;
                end
            end
            fl_pkg::L_RDATA: begin
                next_lk.cnt = lcnt;
                if (byte_end) begin
                    next_lk.cnt = '0;
                    next_lk.addr = b.addr + 24'h000001;
                end
            end
            fl_pkg::L_PDATA: begin
                sv = shin({16'h0000, b.dsh}, dq_i, lw);
                next_lk.dsh = sv[7:0];
                next_lk.cnt = lcnt;
                if (byte_end) begin
                    next_lk.cnt = '0;
                    next_lk.col = b.col + 8'h01;
                    next_lk.got_byte = 1'b1;
                    next_lk.pmask[b.col] = 1'b1;
                    pb_we = 1'b1;
                    pb_dat = sv[7:0];
                end
            end
            default: next_lk.over = 1'b1;
        endcase
    end

    // link state register
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) lk <= fl_pkg::LINK_RST;
        else        lk <= next_lk;
    end

    // page buffer, later bytes of a column overwrite earlier ones
    always_ff @(posedge sclk) begin
        if (pb_we) pbuf[pb_idx] <= pb_dat;
    end

    // read data shifter, changes on falling serial clock edges
    always_comb begin
        logic [7:0] byt;
        logic [2:0] w;
        byt = (ob.ocnt == 4'h0) ? mem[lk.addr[fl_pkg::MEM_AW-1:0]] : ob.osh;
        w = lanes(lk.op, proto, fl_pkg::PH_DATA);
        next_ob = fl_pkg::OUT_RST;
        if (in_frame && lk.st == fl_pkg::L_RDATA) begin
            next_ob.osh = byt << w;
            next_ob.ocnt = ((ob.ocnt == 4'h0) ? 4'h8 : ob.ocnt) - {1'b0, w};
            case (w)
                3'h1: begin
                    next_ob.dq_o = {2'h0, byt[7], 1'b0};
                    next_ob.dq_oe = fl_pkg::OE_ONE;
                end
                3'h2: begin
                    next_ob.dq_o = {2'h0, byt[7:6]};
                    next_ob.dq_oe = fl_pkg::OE_TWO;
                end
                default: begin
                    next_ob.dq_o = byt[7:4];
                    next_ob.dq_oe = fl_pkg::OE_FOUR;
                end
            endcase
        end
    end

    // drivers drop at once when cs_n rises
    always_ff @(negedge sclk or posedge fr_rst) begin
        if (fr_rst) ob <= fl_pkg::OUT_RST;
        else        ob <= next_ob;
    end

    // core side: command commit at cs_n rise, timed programming
    always_comb begin
        logic csr;
        logic clr;
        csr = (c.cs_s[1] == c.cs_s[2]) && c.cs_s[2] && !c.cs_q;
        clr = (c.clr_s[1] == c.clr_s[2]) && c.clr_s[2] && !c.clr_q;
        next_c = c;
        mem_we = 1'b0;
        mem_idx = {c.base, c.col};
        mem_dat = pbuf[c.col];
        next_c.cs_s = {c.cs_s[1:0], cs_n};
        if (c.cs_s[1] == c.cs_s[2]) next_c.cs_q = c.cs_s[2];
        next_c.stl_s = {c.stl_s[1:0], array_stall};
        if (c.stl_s[1] == c.stl_s[2]) next_c.stl_q = c.stl_s[2];
        next_c.clr_s = {c.clr_s[1:0], flag_clr};
        if (c.clr_s[1] == c.clr_s[2]) next_c.clr_q = c.clr_s[2];
        next_c.lock1 = sector_lock;
        next_c.lock2 = c.lock1;
        next_c.lock3 = c.lock2;
        next_c.lockq = ((c.lock2 ~^ c.lock3) & c.lock3) | ((c.lock2 ^ c.lock3) & c.lockq);
        // clear first so a same-cycle set wins
        if (clr) begin
            next_c.fail = 1'b0;
            next_c.prot = 1'b0;
        end
        // link fields are quiet once cs_n is high, so they are read here
        if (csr) next_c.seen = lk.ftog;
        case (c.st)
            fl_pkg::C_IDLE: begin
                if (csr && lk.ftog != c.seen) begin
                    if (lk.op_done && !lk.over && lk.op == fl_pkg::OP_WREN)
                        next_c.wel = 1'b1;
                    else if (lk.op_done && !lk.over && lk.op == fl_pkg::OP_WRDI)
                        next_c.wel = 1'b0;
                    else if (lk.st == fl_pkg::L_PDATA && lk.cnt == 5'h00 && lk.got_byte
                             && c.wel) begin
                        if (c.lockq[lk.addr[23:16]]) begin
                            next_c.prot = 1'b1;
                            next_c.fail = 1'b1;
                        end else begin
                            next_c.st = fl_pkg::C_PROG;
                            next_c.wip = 1'b1;
                            next_c.tmr = '0;
                            next_c.col = '0;
                            next_c.base = lk.addr[fl_pkg::MEM_AW-1:8];
                        end
                    end
                end
            end
            fl_pkg::C_PROG: begin
                next_c.tmr = c.tmr + 10'h001;
                if (!c.stl_q) begin
                    mem_we = lk.pmask[c.col];
                    next_c.col = c.col + 8'h01;
                end
                if (!c.stl_q && c.col == 8'hFF) begin
                    next_c.st = fl_pkg::C_IDLE;
                    next_c.wip = 1'b0;
                    next_c.wel = 1'b0;
                end else if (c.tmr == 10'(fl_pkg::PP_CYC - 1)) begin
                    next_c.st = fl_pkg::C_IDLE;
                    next_c.wip = 1'b0;
                    next_c.wel = 1'b0;
                    next_c.fail = 1'b1;
                end
            end
            default: next_c.st = fl_pkg::C_IDLE;
        endcase
    end

    // core state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) c <= fl_pkg::CORE_RST;
        else        c <= next_c;
    end

    // array model write port
    always_ff @(posedge ref_clk) begin
        if (mem_we) mem[mem_idx] <= mem_dat;
    end

    // status pins straight from core flops, data lanes from the output flops
    assign wip = c.wip;
    assign wel = c.wel;
    assign prog_fail = c.fail;
    assign prot_err = c.prot;
    assign dq_o = ob.dq_o;
    assign dq_oe = ob.dq_oe;

    // commit strobe as the core sees it, watched by wip_start_a below
    logic csr_seen;
    assign csr_seen = (c.cs_s[1] == c.cs_s[2]) && c.cs_s[2] && !c.cs_q;

    // checks on the core clock
    wel_drop_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n) $fell(c.wip) |-> !c.wel)
        else $error("latch still set after program");
    pp_bound_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n) $rose(c.wip) |-> ##[1:PP_LIM] !c.wip)
        else $error("program ran past its time limit");
    wip_start_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n) $rose(c.wip) |-> $past(c.wel) && $past(csr_seen))
        else $error("busy rose without latch or commit");
    prot_keep_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(c.prot) |-> c.wel && c.fail && !c.wip)
        else $error("protected program handled wrongly");
    fail_wel_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(c.fail) && !c.prot |-> !c.wel && !c.wip)
        else $error("timeout left latch or busy set");
    cs_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n) cs_n && $past(cs_n) |-> dq_oe == 4'h0)
        else $error("data driven with cs_n high");

    // checks on the serial clock
    addr_inc_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        in_frame && lk.st == fl_pkg::L_RDATA && byte_end |=> lk.addr == $past(lk.addr) + 24'h1)
        else $error("read address did not advance");
    col_wrap_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        in_frame && lk.st == fl_pkg::L_PDATA && byte_end |=> lk.col == $past(lk.col) + 8'h1)
        else $error("page column did not wrap in page");
    no_dummy_a: assert property (
        @(posedge sclk) disable iff (!rst_n)
        $past(lk.st) == fl_pkg::L_ADDR && lk.st == fl_pkg::L_RDATA |-> lk.op == fl_pkg::OP_READ)
        else $error("fast read skipped dummy clocks");
    ext_line_a: assert property (
        @(negedge sclk) disable iff (!rst_n)
        ob.dq_oe != 4'h0 && proto == fl_pkg::PR_EXT
        && (lk.op == fl_pkg::OP_READ || lk.op == fl_pkg::OP_FAST) |-> ob.dq_oe == fl_pkg::OE_ONE)
        else $error("single read drove the wrong lane");
endmodule

// ===== dv/spi_host.sv
// host model: drives serial clock, chip select and lanes in mode 0
// assumes the bench calls its tasks; serial clock stands still between frames
`timescale 1ns/100ps
module spi_host (
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      dq_i,
    input  wire logic [3:0] dq_o,
    input  wire logic [3:0] dq_oe
);
    logic [3:0] hv;
    // driven device lanes win; released host lanes flip every step
    always_comb for (int k = 0; k < 4; k++) dq_i[k] = dq_oe[k] ? dq_o[k] : hv[k];
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        hv = 4'h5;
    end
    // one lane group per clock, msb first; returning lanes sampled at the rise
    task automatic xfer(input logic [7:0] b, input int w, input bit drv, output logic [7:0] r);
        logic [7:0] sh;
        sh = b;
        r = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            hv = ~hv;
            if (drv && w == 1) hv[0] = sh[7];
            if (drv && w == 2) hv[1:0] = sh[7:6];
            if (drv && w == 4) hv = sh[7:4];
            #80 sclk = 1'b1;
            r = (w == 1) ? {r[6:0], dq_i[1]} : (w == 2) ? {r[5:0], dq_i[1:0]} : {r[3:0], dq_i};
            #80 sclk = 1'b0;
            sh = sh << w;
        end
    endtask
    // a lone clock, used to end a frame off a byte boundary
    task automatic tick();
        hv = ~hv;
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
    endtask
    task automatic begin_frame();
        cs_n = 1'b0;
        #80;
    endtask
    task automatic end_frame();
        #80 cs_n = 1'b1;
        hv = ~hv;
        #240;
    endtask
endmodule

// ===== dv/test_serial_flash_read_program.sv
// bench for the flash sequencer: lane use, reads, programs, flags
// assumes fl_seq and the host model spi_host; core clock 50 MHz
`timescale 1ns/100ps
module test_serial_flash_read_program;
    logic         ref_clk;
    logic         rst_n;
    logic         sclk;
    logic         cs_n;
    logic [3:0]   dq_i;
    logic [3:0]   dq_o;
    logic [3:0]   dq_oe;
    logic [1:0]   proto;
    logic [255:0] sector_lock;
    logic         array_stall;
    logic         flag_clr;
    logic         wip;
    logic         wel;
    logic         prog_fail;
    logic         prot_err;
    logic [7:0]   mem [4096];
    logic [7:0]   rops [6] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
    int           bad_count;
    int           cmp_count;

    fl_seq fl_seq_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .proto(proto), .sector_lock(sector_lock),
        .array_stall(array_stall), .flag_clr(flag_clr), .wip(wip), .wel(wel),
        .prog_fail(prog_fail), .prot_err(prot_err));
    spi_host spi_host_inst (.sclk(sclk), .cs_n(cs_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // lanes per phase: 0 opcode, 1 address, 2 data
    function automatic int lw(input logic [7:0] op, input logic [1:0] pr, input int ph);
        if (pr == fl_pkg::PR_DUAL) return 2;
        if (pr == fl_pkg::PR_QUAD) return 4;
        if (ph == 0) return 1;
        case (op)
            8'hBB, 8'hD2: return 2;
            8'hEB, 8'h12: return 4;
            8'h3B, 8'hA2: return ph == 2 ? 2 : 1;
            8'h6B, 8'h32: return ph == 2 ? 4 : 1;
            default: return 1;
        endcase
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // status as {wip, wel, prog_fail, prot_err}
    task automatic chk_stat(input logic [3:0] exp);
        cmp_count++;
        if ({wip, wel, prog_fail, prot_err} !== exp) begin
            bad_count++;
            $display("wrong value at %0t: status %b", $time, {wip, wel, prog_fail, prot_err});
        end
    endtask
    task automatic results();
        $display("mismatches %0d, compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(posedge ref_clk);
        #2;
    endtask
    task automatic wait_wip(input logic v);
        int k;
        k = 0;
        while (wip !== v && k < 2000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k == 2000) chk_byte(8'h00, 8'h01);
        settle();
    endtask
    task automatic op_only(input logic [7:0] op);
        logic [7:0] r;
        spi_host_inst.begin_frame();
        spi_host_inst.xfer(op, lw(op, proto, 0), 1'b1, r);
        spi_host_inst.end_frame();
        settle();
    endtask
    // write enable, then program; the model follows the column wrap
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input bit upd,
        input bit odd);
        logic [7:0] r;
        logic [7:0] d;
        op_only(8'h06);
        spi_host_inst.begin_frame();
        spi_host_inst.xfer(op, lw(op, proto, 0), 1'b1, r);
        for (int i = 2; i >= 0; i--) spi_host_inst.xfer(a[8*i+:8], lw(op, proto, 1), 1'b1, r);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            spi_host_inst.xfer(d, lw(op, proto, 2), 1'b1, r);
            if (upd) mem[{a[11:8], 8'(a[7:0] + 8'(i))}] = d;
        end
        if (odd) spi_host_inst.tick();
        spi_host_inst.end_frame();
        settle();
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n, input bit ok);
        logic [7:0] r;
        int w;
        w = lw(op, proto, 2);
        spi_host_inst.begin_frame();
        spi_host_inst.xfer(op, lw(op, proto, 0), 1'b1, r);
        for (int i = 2; i >= 0; i--) spi_host_inst.xfer(a[8*i+:8], lw(op, proto, 1), 1'b1, r);
        if (op != 8'h03) spi_host_inst.xfer(8'h00, 1, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            spi_host_inst.xfer(8'h00, w, 1'b0, r);
            if (ok) chk_byte(r, mem[12'(a + 24'(i))]);
        end
        #40;
        chk_byte({4'h0, dq_oe}, ok ? {4'h0, w == 1 ? 4'h2 : w == 2 ? 4'h3 : 4'hF} : 8'h00);
        spi_host_inst.end_frame();
        chk_byte({4'h0, dq_oe}, 8'h00);
        settle();
    endtask

    initial begin
        rst_n = 1'b0;
        proto = fl_pkg::PR_EXT;
        sector_lock = '0;
        array_stall = 1'b0;
        flag_clr = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(9));
        repeat (3) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        chk_stat(4'h0);
        settle();
        op_only(8'h06);
        chk_stat(4'h4);
        op_only(8'h04);
        chk_stat(4'h0);
        // page wrap, then a short program inside the same page
        prog(8'h02, {12'($urandom), 12'h0F0}, 40, 1'b1, 1'b0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        chk_stat(4'h0);
        prog(8'h02, {12'($urandom), 12'h0F4}, 2, 1'b1, 1'b0);
        wait_wip(1'b0);
        // overflow past one page on four lanes
        prog(8'h12, 24'h000110, 260, 1'b1, 1'b0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        rd(8'h03, 24'h000100, 8, 1'b1);
        // two of the three remaining program forms, read back with a fast read
        prog(8'hA2, 24'h000200, 3, 1'b1, 1'b0);
        wait_wip(1'b0);
        prog(8'h32, 24'h000203, 3, 1'b1, 1'b0);
        wait_wip(1'b0);
        rd(8'h0B, 24'h000200, 6, 1'b1);
        for (int p = 0; p < 3; p++) begin
            proto = 2'(p);
            foreach (rops[j]) rd(rops[j], {12'($urandom), 12'h0F0 + 12'($urandom_range(0, 15))},
                8, p == 0 || (p == 1 && j inside {1, 2, 3}) || (p == 2 && j inside {1, 4, 5}));
        end
        proto = fl_pkg::PR_EXT;
        // ends off a byte boundary: discarded
        prog(8'hD2, 24'h000500, 3, 1'b0, 1'b1);
        chk_stat(4'h4);
        sector_lock[5] = 1'b1;
        prog(8'h02, 24'h050300, 4, 1'b0, 1'b0);
        chk_stat(4'h7);
        sector_lock[5] = 1'b0;
        flag_clr = 1'b1;
        settle();
        flag_clr = 1'b0;
        settle();
        chk_stat(4'h4);
        array_stall = 1'b1;
        prog(8'h02, 24'h000700, 4, 1'b0, 1'b0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        chk_stat(4'h2);
        array_stall = 1'b0;
        results();
    end
    initial begin
        #1_000_000;
        bad_count++;
        results();
    end
endmodule
